//--- rtl/sost_pkg.sv
// constants and types for the shutter output select and trigger block
package sost_pkg;

    // register addresses on the serial port
    localparam logic [11:0] SOST_ADDR_SELECT = 12'h060;
    localparam logic [11:0] SOST_ADDR_TRIGGER = 12'h061;

    // register widths and reset values
    localparam int SOST_SELECT_W = 12;
    localparam int SOST_TRIGGER_W = 8;
    localparam logic [11:0] SOST_SELECT_RST = 12'h000;
    localparam logic [7:0] SOST_TRIGGER_RST = 8'h00;

    // serial frame layout: address first, then data, lsb first
    localparam int SOST_SER_ADDR_W = 12;
    localparam int SOST_SER_DATA_W = 28;
    localparam int SOST_SER_FRAME_W = SOST_SER_ADDR_W + SOST_SER_DATA_W;

    // select field positions
    localparam int SOST_SEL_FIELD_W = 3;
    localparam int SOST_SEL_SUBSTRATE_LSB = 0;
    localparam int SOST_SEL_MECH_LSB = 3;
    localparam int SOST_SEL_STROBE_LSB = 6;
    localparam int SOST_SEL_TEST_LSB = 9;

    // trigger bit positions
    localparam int SOST_TRIG_ALL_SHUT = 0;
    localparam int SOST_TRIG_SHUTTER_SEQ_1 = 1;
    localparam int SOST_TRIG_SHUTTER_SEQ_2 = 2;
    localparam int SOST_TRIG_SHUTTER_SEQ_3 = 3;
    localparam int SOST_TRIG_SUB0 = 4;
    localparam int SOST_TRIG_SUB1 = 5;
    localparam int SOST_TRIG_EXPOSURE = 6;
    localparam int SOST_TRIG_READOUT = 7;

    // common source encoding of every select field
    typedef enum logic [2:0] {
        SOST_SRC_SHUTTER_SEQ_0 = 3'h0,
        SOST_SRC_SHUTTER_SEQ_1 = 3'h1,
        SOST_SRC_SHUTTER_SEQ_2 = 3'h2,
        SOST_SRC_SHUTTER_SEQ_3 = 3'h3,
        SOST_SRC_MUX_A = 3'h4,
        SOST_SRC_MUX_B = 3'h5,
        SOST_SRC_INVALID = 3'h6,
        SOST_SRC_PAIR = 3'h7
    } sost_src_t;

    // internal timing sources offered to the output selects
    typedef struct packed {
        logic [3:0] shutter_seq;
        logic substrate_bias_mux_a;
        logic substrate_bias_mux_b;
        logic shutter_pair_mux;
    } sost_sources_t;

    // start pulses handed to the sequence generators
    typedef struct packed {
        logic [3:0] shutter_seq_start;
        logic [1:0] substrate_bias_seq_start;
        logic exposure_start;
        logic readout_start;
    } sost_starts_t;

endpackage

//--- rtl/sost_top.sv
// shutter output source select and exposure/readout trigger registers
//
// Contract
// (R1) substrate-bias pin follows select bits 2:0
// (R2) mechanical-shutter pin follows select bits 5:3
// (R3) strobe pin follows select bits 8:6
// (R4) test output follows select bits 11:9
// (R5) codes 0-3 route shutter sequences 0-3
// (R6) codes 4,5,7 route muxes; 6 invalid
// (R7) trigger bits 1-6 start their own sequences
// (R8) trigger bit 0 starts all four shutters
// (R9) joint readout waits for exposure completion
// (R10) writes take effect at next vertical sync
module sost_top
    import sost_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // 3-wire serial port, sampled on clk
    input wire logic ser_load_n,
    input wire logic ser_clk,
    input wire logic ser_data,
    // frame timing and sequence status
    input wire logic vertical_sync,
    input wire logic exposure_done,
    // internal timing sources
    input wire sost_sources_t sources,
    // output pins
    output logic substrate_bias_pin,
    output logic mech_shutter_pin,
    output logic strobe_pin,
    output logic test_out_signal,
    // start pulses to the generators
    output sost_starts_t starts,
    // applied register contents
    output logic [SOST_SELECT_W-1:0] select_active,
    output logic [SOST_TRIGGER_W-1:0] trigger_active
);

    // serial shifter state
    logic [SOST_SER_FRAME_W-1:0] shift_r; // incoming frame, lsb first
    logic ser_clk_d_r; // previous serial clock level
    logic ser_load_d_r; // previous load level

    // shadow registers written by the host
    logic [SOST_SELECT_W-1:0] select_shadow_r;
    logic [SOST_TRIGGER_W-1:0] trigger_shadow_r;
    logic trigger_pend_r; // trigger written, not yet applied

    // applied registers
    logic [SOST_SELECT_W-1:0] select_r;
    logic [SOST_TRIGGER_W-1:0] trigger_r;

    // frame and sync events
    logic vsync_d_r; // previous vertical sync level
    logic vsync_rise; // vertical sync boundary
    logic frame_done; // load rose: frame complete
    logic [SOST_SER_ADDR_W-1:0] frame_addr;
    logic [SOST_SER_DATA_W-1:0] frame_data;

    // readout held behind an exposure in flight
    logic readout_wait_r;

    // registered outputs
    logic [3:0] pins_r;
    sost_starts_t starts_r;

    // pick one source by the common encoding
    function automatic logic route_src(input logic [SOST_SEL_FIELD_W-1:0] code,
                                       input sost_sources_t src);
        logic val;
        val = 1'b0;
        unique case (sost_src_t'(code))
            SOST_SRC_SHUTTER_SEQ_0: val = src.shutter_seq[0]; // [R5]
            SOST_SRC_SHUTTER_SEQ_1: val = src.shutter_seq[1]; // [R5]
            SOST_SRC_SHUTTER_SEQ_2: val = src.shutter_seq[2]; // [R5]
            SOST_SRC_SHUTTER_SEQ_3: val = src.shutter_seq[3]; // [R5]
            SOST_SRC_MUX_A: val = src.substrate_bias_mux_a; // [R6]
            SOST_SRC_MUX_B: val = src.substrate_bias_mux_b; // [R6]
            // invalid code parks the output low rather than glitching
            SOST_SRC_INVALID: val = 1'b0; // [R6]
            SOST_SRC_PAIR: val = src.shutter_pair_mux; // [R6]
        endcase
        return val;
    endfunction

    // edge events; serial pins are treated as synchronous
    assign vsync_rise = vertical_sync && !vsync_d_r;
    assign frame_done = ser_load_n && !ser_load_d_r;
    assign frame_addr = shift_r[SOST_SER_ADDR_W-1:0];
    assign frame_data = shift_r[SOST_SER_FRAME_W-1:SOST_SER_ADDR_W];

    // edge history
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            ser_clk_d_r <= 1'b0;
            ser_load_d_r <= 1'b1;
            vsync_d_r <= 1'b0;
        end
        else
        begin
            ser_clk_d_r <= ser_clk;
            ser_load_d_r <= ser_load_n;
            vsync_d_r <= vertical_sync;
        end
    end

    // shift on each serial clock rise while load is low
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            shift_r <= '0;
        end
        else if (!ser_load_n && ser_clk && !ser_clk_d_r)
        begin
            // new bit enters at the top so the first bit ends at bit 0
            shift_r <= {ser_data, shift_r[SOST_SER_FRAME_W-1:1]};
        end
    end

    // shadow select register, held until vertical sync
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            select_shadow_r <= SOST_SELECT_RST;
        end
        else if (frame_done && frame_addr == SOST_ADDR_SELECT)
        begin
            select_shadow_r <= frame_data[SOST_SELECT_W-1:0];
        end
    end

    // shadow trigger; a write in the sync cycle survives the hand-off
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            trigger_shadow_r <= SOST_TRIGGER_RST;
            trigger_pend_r <= 1'b0;
        end
        else if (frame_done && frame_addr == SOST_ADDR_TRIGGER)
        begin
            trigger_shadow_r <= frame_data[SOST_TRIGGER_W-1:0]; // [R7]
            trigger_pend_r <= 1'b1;
        end
        else if (vsync_rise)
        begin
            // triggers are one-shot: consumed at the boundary
            trigger_shadow_r <= SOST_TRIGGER_RST;
            trigger_pend_r <= 1'b0;
        end
    end

    // apply shadows at the vertical sync boundary
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            select_r <= SOST_SELECT_RST;
            trigger_r <= SOST_TRIGGER_RST;
        end
        else if (vsync_rise)
        begin
            select_r <= select_shadow_r; // [R10]
            trigger_r <= trigger_pend_r ? trigger_shadow_r : SOST_TRIGGER_RST; // [R10]
        end
    end

    // readout joined to an exposure waits for its end
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            readout_wait_r <= 1'b0;
        end
        else if (vsync_rise && trigger_pend_r && trigger_shadow_r[SOST_TRIG_EXPOSURE]
                 && trigger_shadow_r[SOST_TRIG_READOUT])
        begin
            readout_wait_r <= 1'b1; // [R9]
        end
        else if (exposure_done)
        begin
            readout_wait_r <= 1'b0; // [R9]
        end
    end

    // start pulses, one cycle after the boundary
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            starts_r <= '0;
        end
        else
        begin
            starts_r <= '0;
            if (vsync_rise && trigger_pend_r)
            begin
                // bit 0 fires all shutters; bits 1-3 single ones
                starts_r.shutter_seq_start[0] <= trigger_shadow_r[SOST_TRIG_ALL_SHUT]; // [R8]
                starts_r.shutter_seq_start[1] <= trigger_shadow_r[SOST_TRIG_ALL_SHUT]
                    | trigger_shadow_r[SOST_TRIG_SHUTTER_SEQ_1]; // [R7] [R8]
                starts_r.shutter_seq_start[2] <= trigger_shadow_r[SOST_TRIG_ALL_SHUT]
                    | trigger_shadow_r[SOST_TRIG_SHUTTER_SEQ_2]; // [R7] [R8]
                starts_r.shutter_seq_start[3] <= trigger_shadow_r[SOST_TRIG_ALL_SHUT]
                    | trigger_shadow_r[SOST_TRIG_SHUTTER_SEQ_3]; // [R7] [R8]
                starts_r.substrate_bias_seq_start[0] <= trigger_shadow_r[SOST_TRIG_SUB0]; // [R7]
                starts_r.substrate_bias_seq_start[1] <= trigger_shadow_r[SOST_TRIG_SUB1]; // [R7]
                starts_r.exposure_start <= trigger_shadow_r[SOST_TRIG_EXPOSURE]; // [R7]
                // readout alone starts at once; with exposure it is deferred
                starts_r.readout_start <= trigger_shadow_r[SOST_TRIG_READOUT]
                    && !trigger_shadow_r[SOST_TRIG_EXPOSURE]; // [R9]
            end
            else if (readout_wait_r && exposure_done)
            begin
                starts_r.readout_start <= 1'b1; // [R9]
            end
        end
    end

    // output pin routing, registered to avoid mux glitches on the pins
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            pins_r <= '0;
        end
        else
        begin
            pins_r[0] <= route_src(select_r[SOST_SEL_SUBSTRATE_LSB +: SOST_SEL_FIELD_W],
                                   sources); // [R1]
            pins_r[1] <= route_src(select_r[SOST_SEL_MECH_LSB +: SOST_SEL_FIELD_W],
                                   sources); // [R2]
            pins_r[2] <= route_src(select_r[SOST_SEL_STROBE_LSB +: SOST_SEL_FIELD_W],
                                   sources); // [R3]
            pins_r[3] <= route_src(select_r[SOST_SEL_TEST_LSB +: SOST_SEL_FIELD_W],
                                   sources); // [R4]
        end
    end

    // drive ports from flip-flops
    assign substrate_bias_pin = pins_r[0];
    assign mech_shutter_pin = pins_r[1];
    assign strobe_pin = pins_r[2];
    assign test_out_signal = pins_r[3];
    assign starts = starts_r;
    assign select_active = select_r;
    assign trigger_active = trigger_r;

endmodule

//--- test/sost_partner.sv
// far-side model: timing sources and the end of exposure
module sost_partner
    import sost_pkg::*;
#(
    parameter int EXP_DLY = 6
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // start pulses from the block
    input wire sost_starts_t starts,
    // modelled sources and status
    output sost_sources_t sources,
    output logic exposure_done
);
    timeunit 1ns;
    timeprecision 1ps;
    sost_sources_t src_r = 7'h00; // source pattern
    logic done_r = 1'b0; // exposure end pulse
    int cnt_r = 0; // cycles left in exposure
    assign sources = src_r;
    assign exposure_done = done_r;

    // odd step walks all patterns, so a stale source never matches for long
    always @(posedge clk) src_r <= #1 src_r + 7'h25;

    // exposure ends a fixed time after its start, one-cycle pulse
    always @(posedge clk)
    begin
        done_r <= #1 (cnt_r == 1);
        if (!rstn) cnt_r <= 0;
        else if (starts.exposure_start) cnt_r <= EXP_DLY;
        else if (cnt_r != 0) cnt_r <= cnt_r - 1;
    end
endmodule

//--- test/sost_top_properties.sv
// assertion checker for the shutter select and trigger block
module sost_top_properties
    import sost_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // inputs seen by the block
    input wire logic vertical_sync,
    input wire logic exposure_done,
    input wire sost_sources_t sources,
    // outputs under check
    input wire logic substrate_bias_pin,
    input wire logic mech_shutter_pin,
    input wire logic strobe_pin,
    input wire logic test_out_signal,
    input wire sost_starts_t starts,
    input wire logic [SOST_SELECT_W-1:0] select_active,
    input wire logic [SOST_TRIGGER_W-1:0] trigger_active
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // source behind one code; code 6 reads as 0
    function automatic logic pick(logic [2:0] c, sost_sources_t s);
        logic [7:0] v;
        v = {s.shutter_pair_mux, 1'b0, s.substrate_bias_mux_b, s.substrate_bias_mux_a,
             s.shutter_seq};
        return v[c];
    endfunction

    // pins lag their source by one cycle; two edges after reset are skipped
    property p_sub;
        $past(rstn, 2) |-> substrate_bias_pin == $past(pick(select_active[2:0], sources));
    endproperty
    a_sub: assert property (p_sub) else $error("bad substrate pin");
    property p_mech;
        $past(rstn, 2) |-> mech_shutter_pin == $past(pick(select_active[5:3], sources));
    endproperty
    a_mech: assert property (p_mech) else $error("bad shutter pin");
    property p_strobe;
        $past(rstn, 2) |-> strobe_pin == $past(pick(select_active[8:6], sources));
    endproperty
    a_strobe: assert property (p_strobe) else $error("bad strobe pin");
    property p_test;
        $past(rstn, 2) |-> test_out_signal == $past(pick(select_active[11:9], sources));
    endproperty
    a_test: assert property (p_test) else $error("bad test output");

    // start pulses must match the applied trigger value
    property p_shut;
        starts.shutter_seq_start != 4'h0 |-> starts.shutter_seq_start ==
            ({4{trigger_active[0]}} | {trigger_active[3:1], 1'b0});
    endproperty
    a_shut: assert property (p_shut) else $error("bad shutter starts");
    property p_subs;
        starts.substrate_bias_seq_start != 2'h0 |->
            starts.substrate_bias_seq_start == trigger_active[5:4];
    endproperty
    a_subs: assert property (p_subs) else $error("bad substrate starts");
    property p_exp;
        starts.exposure_start |->
            trigger_active[6] && $past(vertical_sync) && !$past(vertical_sync, 2);
    endproperty
    a_exp: assert property (p_exp) else $error("bad exposure start");
    // joint readout waits for the end of exposure
    property p_ro;
        starts.readout_start |-> trigger_active[7] &&
            (trigger_active[6] ? $past(exposure_done) : $past(vertical_sync));
    endproperty
    a_ro: assert property (p_ro) else $error("bad readout start");
    // selection only moves just after a vertical sync rise
    property p_sel;
        !$stable(select_active) |-> $past(vertical_sync) && !$past(vertical_sync, 2);
    endproperty
    a_sel: assert property (p_sel) else $error("select moved off boundary");
endmodule

bind sost_top sost_top_properties u_props (
    .clk(clk), .rstn(rstn), .vertical_sync(vertical_sync), .exposure_done(exposure_done),
    .sources(sources), .substrate_bias_pin(substrate_bias_pin),
    .mech_shutter_pin(mech_shutter_pin), .strobe_pin(strobe_pin),
    .test_out_signal(test_out_signal), .starts(starts), .select_active(select_active),
    .trigger_active(trigger_active));

//--- test/sost_top_tb.sv
// self-checking bench for the shutter select and trigger block
module sost_top_tb
    import sost_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic ser_load_n = 1'b1;
    logic ser_clk = 1'b0;
    logic ser_data = 1'b0;
    logic vertical_sync = 1'b0;
    logic exposure_done, sub_pin, mech_pin, strobe_pin, test_pin;
    sost_sources_t sources;
    sost_starts_t starts;
    logic [11:0] select_active;
    logic [7:0] trigger_active;
    int fail_count = 0;
    int n_checks = 0;

    always #2 clk = ~clk;

    sost_top dut (.clk(clk), .rstn(rstn), .ser_load_n(ser_load_n), .ser_clk(ser_clk),
        .ser_data(ser_data), .vertical_sync(vertical_sync), .exposure_done(exposure_done),
        .sources(sources), .substrate_bias_pin(sub_pin), .mech_shutter_pin(mech_pin),
        .strobe_pin(strobe_pin), .test_out_signal(test_pin), .starts(starts),
        .select_active(select_active), .trigger_active(trigger_active));
    sost_partner partner (.clk(clk), .rstn(rstn), .starts(starts), .sources(sources),
        .exposure_done(exposure_done));

    // inputs always change 1 ns after the edge
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic check(logic [11:0] seen, logic [11:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        if (fail_count == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // one 40-bit frame, address then data, lsb first
    task automatic ser_write(logic [11:0] a, logic [27:0] d);
        logic [SOST_SER_FRAME_W-1:0] f;
        f = {d, a};
        ser_load_n = 1'b0;
        for (int i = 0; i < SOST_SER_FRAME_W; i++)
        begin
            ser_data = f[i];
            ser_clk = 1'b0;
            tick(2);
            ser_clk = 1'b1;
            tick(2);
        end
        ser_clk = 1'b0;
        ser_load_n = 1'b1;
        tick(2);
    endtask
    // one-cycle boundary; returns in the cycle the start pulses stand
    task automatic vsync();
        vertical_sync = 1'b1;
        tick(1);
        // a longer pulse would let the one-cycle starts pass before the look
        vertical_sync = 1'b0;
        @(negedge clk);
    endtask
    // expected pins from a select word and the sources
    function automatic logic [3:0] pins4(logic [11:0] s, sost_sources_t x);
        logic [7:0] v;
        v = {x.shutter_pair_mux, 1'b0, x.substrate_bias_mux_b, x.substrate_bias_mux_a,
             x.shutter_seq};
        return {v[s[11:9]], v[s[8:6]], v[s[5:3]], v[s[2:0]]};
    endfunction

    // every code in every field, unmapped write ignored, applied at boundary
    task automatic test_select();
        logic [11:0] s;
        logic [11:0] last = 12'h000;
        sost_sources_t seen;
        for (int c = 0; c < 8; c++)
        begin
            s = {3'(c + 3), 3'(c + 2), 3'(c + 1), 3'(c)};
            ser_write(SOST_ADDR_SELECT, 28'(s));
            ser_write(12'h062, 28'hfff);
            check(select_active, last);
            vsync();
            check(select_active, s);
            last = s;
            @(negedge clk);
            repeat (4)
            begin
                seen = sources;
                @(negedge clk);
                check(12'({test_pin, strobe_pin, mech_pin, sub_pin}), 12'(pins4(s, seen)));
            end
            tick(1);
        end
    endtask
    // readout must come the cycle after exposure end
    task automatic test_readout();
        int nd = 100;
        int nr = 0;
        for (int i = 1; i < 40 && nr == 0; i++)
        begin
            @(negedge clk);
            if (exposure_done === 1'b1) nd = i;
            if (starts.readout_start === 1'b1) nr = i;
        end
        check(12'(nr), 12'(nd + 1));
        tick(1);
    endtask
    // each trigger bit, then exposure with readout
    task automatic test_trigger();
        logic [7:0] t;
        logic [7:0] tv[9] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80, 8'hc0};
        foreach (tv[i])
        begin
            t = tv[i];
            ser_write(SOST_ADDR_TRIGGER, 28'(t));
            check(12'(starts), 12'h000);
            vsync();
            check(12'(starts), 12'({{t[3:1], 1'b0} | {4{t[0]}}, t[5:4], t[6], t[7] & ~t[6]}));
            check(12'(trigger_active), 12'(t));
            if (t == 8'hc0) test_readout();
            else tick(1);
        end
        // no write since the last boundary: triggers are one-shot
        vsync();
        check(12'(starts), 12'h000);
        check(12'(trigger_active), 12'(SOST_TRIGGER_RST));
        tick(1);
    endtask

    // main sequence
    initial
    begin
        tick(16);
        rstn = 1'b1;
        tick(1);
        check(select_active, SOST_SELECT_RST);
        check(12'(trigger_active), 12'(SOST_TRIGGER_RST));
        test_select();
        test_trigger();
        summarize();
    end
    // watchdog, about six times the expected run
    initial
    begin
        #100000;
        fail_count++;
        summarize();
    end
endmodule
